// file: sbm_buffer.sv
// Two-entry valid/ready buffer for the serial product stream.
// Assumes one clock; flush empties it and zeroes the output data.
`timescale 1ns/1ps
module sbm_buffer
    import sbm_pkg::*;
#(
    parameter int WIDTH = 1
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic flush_i,
    input wire logic in_valid_i,
    input wire logic [WIDTH-1:0] in_data_i,
    output logic in_ready_o,
    output logic out_valid_o,
    output logic [WIDTH-1:0] out_data_o,
    input wire logic out_ready_i
);

    logic [WIDTH-1:0] tail;
    logic [BUF_CNT_W-1:0] count;
    logic push;
    logic pop;

    assign in_ready_o = (count != BUF_CNT_W'(BUF_DEPTH));
    assign out_valid_o = (count != '0);
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    // ----------------------------------------------------------------
    // Occupancy
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            count <= '0;
        end else if (flush_i) begin
            count <= '0;
        end else if (push && !pop) begin
            count <= count + BUF_CNT_W'(1);
        end else if (pop && !push) begin
            count <= count - BUF_CNT_W'(1);
        end
    end

    // ----------------------------------------------------------------
    // Storage: head is the output flop, tail the second slot
    // ----------------------------------------------------------------
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            out_data_o <= '0;
            tail <= '0;
        end else if (flush_i) begin
            out_data_o <= '0;
            tail <= '0;
        end else begin
            if (pop) begin
                out_data_o <= (count == BUF_CNT_W'(BUF_DEPTH)) ? tail
                                                               : in_data_i;
            end else if (push && count == '0) begin
                out_data_o <= in_data_i;
            end
            if (push && (count == BUF_CNT_W'(BUF_DEPTH) ||
                         (count != '0 && !pop))) begin
                tail <= in_data_i;
            end
        end
    end

endmodule : sbm_buffer

// file: sbm_host_model.sv
// Host model: feeds the serial multiplier, collects the product.
// Assumes the bench owns clear and multiplicand; go starts a run.
`timescale 1ns/1ps
module sbm_host_model
    import sbm_pkg::*;
(
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [7:0] mult_i,
    input wire logic stall_i,
    input wire logic ready_i,
    input wire logic res_bit_i,
    input wire logic res_valid_i,
    output logic bit_o = 1'b0,
    output logic valid_o = 1'b0,
    output logic res_ready_o,
    output logic [15:0] result_serial_out_o = '0,
    output logic done_o = 1'b0
);
    int sent = 0;
    int got = 0;
    logic run = 1'b0;

    assign res_ready_o = ~stall_i;

    always @(posedge clk_i) begin
        run = go_i;
        if (!go_i) begin
            sent = 0;
            got = 0;
        end else begin
            if (valid_o && ready_i) sent++;
            if (res_valid_i && res_ready_o && got < 16) begin
                result_serial_out_o[got] = res_bit_i;
                got++;
            end
        end
    end

    // Idle line toggles so a stale bit is never mistaken for data
    always @(negedge clk_i) begin
        valid_o <= run && sent < 16;
        bit_o <= (run && sent < 16) ? mult_i[sent > 7 ? 7 : sent] : ~bit_o;
        done_o <= run && got == 16;
    end
endmodule : sbm_host_model

// file: sbm_pkg.sv
// Constants and types for the serial Booth multiplier slice.
// Assumes a single 40 MHz clock domain; no software-visible registers.
package sbm_pkg;

    // ----------------------------------------------------------------
    // Widths and depths
    // ----------------------------------------------------------------
    localparam int MCAND_W = 8;
    localparam int SUM_W = MCAND_W + 1;
    localparam int BUF_DEPTH = 2;
    localparam int BUF_CNT_W = 2;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [MCAND_W-1:0] MCAND_RST = 8'h00;
    localparam logic [MCAND_W-1:0] SUM_RST = 8'h00;
    localparam logic PREV_RST = 1'b0;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int CLK_PERIOD_PS = 25000;

    // Booth step chosen from current and previous multiplier bits
    typedef enum logic [1:0] {
        SBM_OP_SHIFT,
        SBM_OP_ADD,
        SBM_OP_SUB
    } sbm_op_t;

endpackage : sbm_pkg

// file: sbm_slice.sv
// Eight-bit by one-bit serial-parallel Booth multiplier slice.
// Assumes inputs synchronous to CLOCK_I; clear is sampled on the clock.
`timescale 1ns/1ps

// Behaviour
// - Hold multiplicand, Booth product needs no correction
// - Clear low resets state, output low, loads
// - Clear high freezes multiplicand latches
// - Product leaves serially, LSB first, per edge
// - Current low, previous high: add, shift
// - Current high, previous low: subtract, shift
// - Cascade input feeds the sum path
// - Position select: low most significant slice
// - Clear low loads and clears state each cycle
module sbm_slice
    import sbm_pkg::*;
(
    input wire logic CLOCK_I,
    input wire logic RST_I,
    input wire logic CLEAR_N_I,
    input wire logic [MCAND_W-1:0] MCAND_I,
    input wire logic MULT_BIT_I,
    input wire logic MULT_VALID_I,
    output logic MULT_READY_O,
    input wire logic CASCADE_I,
    input wire logic POS_SEL_I,
    output logic RESULT_SERIAL_OUT_O,
    output logic RESULT_VALID_O,
    input wire logic RESULT_READY_I
);

    logic [MCAND_W-1:0] mcand;
    logic [MCAND_W-1:0] sum;
    logic prev_bit;
    logic buf_ready;
    logic step;
    sbm_op_t op;
    logic [SUM_W-1:0] addend;
    logic [SUM_W-1:0] total;
    logic shift_in;
    logic [MCAND_W-1:0] next_sum;

    // A stalled receiver halts stepping, so no product bit is dropped
    assign MULT_READY_O = CLEAR_N_I && buf_ready;
    assign step = MULT_READY_O && MULT_VALID_I;

    // ----------------------------------------------------------------
    // Multiplicand latch
    // ----------------------------------------------------------------
    // Loaded on every clock while clear is low, frozen once it rises
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            mcand <= MCAND_RST;
        end else if (!CLEAR_N_I) begin
            mcand <= MCAND_I;
        end
    end

    // ----------------------------------------------------------------
    // Booth recoding and add/subtract
    // ----------------------------------------------------------------
    always_comb begin
        unique case ({MULT_BIT_I, prev_bit})
            2'b01: op = SBM_OP_ADD;
            2'b10: op = SBM_OP_SUB;
            2'b00, 2'b11: op = SBM_OP_SHIFT;
        endcase
    end

    always_comb begin
        unique case (op)
            SBM_OP_ADD: addend = {mcand[MCAND_W-1], mcand};
            SBM_OP_SUB: addend = SUM_W'(-{mcand[MCAND_W-1], mcand});
            SBM_OP_SHIFT: addend = '0;
        endcase
    end

    // Nine bits hold any signed sum of two eight-bit values
    assign total = {sum[MCAND_W-1], sum} + addend;
    // Lower-order slices take the next slice's output as top bit
    assign shift_in = POS_SEL_I ? CASCADE_I : total[SUM_W-1];
    assign next_sum = {shift_in, total[MCAND_W-1:1]};

    // ----------------------------------------------------------------
    // Sum register
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            sum <= SUM_RST;
        end else if (!CLEAR_N_I) begin
            sum <= SUM_RST;
        end else if (step) begin
            sum <= next_sum;
        end
    end

    // ----------------------------------------------------------------
    // Previous multiplier bit
    // ----------------------------------------------------------------
    always_ff @(posedge CLOCK_I or posedge RST_I) begin
        if (RST_I) begin
            prev_bit <= PREV_RST;
        end else if (!CLEAR_N_I) begin
            prev_bit <= PREV_RST;
        end else if (step) begin
            prev_bit <= MULT_BIT_I;
        end
    end

    // ----------------------------------------------------------------
    // Output buffer
    // ----------------------------------------------------------------
    sbm_buffer #(
        .WIDTH(1)
    ) u_buffer (
        .clk_i(CLOCK_I),
        .rst_i(RST_I),
        .flush_i(!CLEAR_N_I),
        .in_valid_i(step),
        .in_data_i(total[0]),
        .in_ready_o(buf_ready),
        .out_valid_o(RESULT_VALID_O),
        .out_data_o(RESULT_SERIAL_OUT_O),
        .out_ready_i(RESULT_READY_I)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    property p_clear_zeroes;
        @(posedge CLOCK_I) disable iff (RST_I)
        !CLEAR_N_I |=> (!RESULT_SERIAL_OUT_O && !prev_bit && sum == '0
                        && !RESULT_VALID_O);
    endproperty
    a_clear_zeroes: assert property (p_clear_zeroes)
        else $error("Clear did not zero the slice state");

    property p_latch_closed;
        @(posedge CLOCK_I) disable iff (RST_I)
        CLEAR_N_I [*2] |-> $stable(mcand);
    endproperty
    a_latch_closed: assert property (p_latch_closed)
        else $error("Multiplicand changed while clear was high");

    property p_latch_load;
        @(posedge CLOCK_I) disable iff (RST_I)
        !CLEAR_N_I |=> mcand == $past(MCAND_I);
    endproperty
    a_latch_load: assert property (p_latch_load)
        else $error("Multiplicand not loaded during clear");

    property p_prev_track;
        @(posedge CLOCK_I) disable iff (RST_I)
        step |=> prev_bit == $past(MULT_BIT_I);
    endproperty
    a_prev_track: assert property (p_prev_track)
        else $error("Previous bit not updated on step");

    property p_shift_only;
        @(posedge CLOCK_I) disable iff (RST_I)
        (step && MULT_BIT_I == prev_bit && !POS_SEL_I) |=>
            sum == {$past(sum[MCAND_W-1]), $past(sum[MCAND_W-1:1])};
    endproperty
    a_shift_only: assert property (p_shift_only)
        else $error("Equal bits did more than shift");

    // Reference sum is nine bits wide, as an eight-bit one would wrap
    property p_add;
        @(posedge CLOCK_I) disable iff (RST_I)
        (step && !MULT_BIT_I && prev_bit && !POS_SEL_I) |=>
            $signed({sum[MCAND_W-1], sum}) ==
                ($signed({$past(sum[MCAND_W-1]), $past(sum)})
                 + $signed({$past(mcand[MCAND_W-1]), $past(mcand)}))
                >>> 1;
    endproperty
    a_add: assert property (p_add)
        else $error("Add step gave wrong sum");

    property p_sub;
        @(posedge CLOCK_I) disable iff (RST_I)
        (step && MULT_BIT_I && !prev_bit && !POS_SEL_I) |=>
            $signed({sum[MCAND_W-1], sum}) ==
                ($signed({$past(sum[MCAND_W-1]), $past(sum)})
                 - $signed({$past(mcand[MCAND_W-1]), $past(mcand)}))
                >>> 1;
    endproperty
    a_sub: assert property (p_sub)
        else $error("Subtract step gave wrong sum");

    property p_cascade;
        @(posedge CLOCK_I) disable iff (RST_I)
        (step && POS_SEL_I) |=> sum[MCAND_W-1] == $past(CASCADE_I);
    endproperty
    a_cascade: assert property (p_cascade)
        else $error("Cascade bit not shifted into lower slice");

    property p_out_bit;
        @(posedge CLOCK_I) disable iff (RST_I)
        (step && !RESULT_VALID_O) |=>
            RESULT_VALID_O && RESULT_SERIAL_OUT_O == $past(total[0]);
    endproperty
    a_out_bit: assert property (p_out_bit)
        else $error("Product bit not presented after step");

    // An unread bit must stand until the receiver takes it
    property p_out_hold;
        @(posedge CLOCK_I) disable iff (RST_I)
        (RESULT_VALID_O && !RESULT_READY_I && CLEAR_N_I) |=>
            RESULT_VALID_O && $stable(RESULT_SERIAL_OUT_O);
    endproperty
    a_out_hold: assert property (p_out_hold)
        else $error("Product bit changed before it was taken");

    property p_stall_hold;
        @(posedge CLOCK_I) disable iff (RST_I)
        (CLEAR_N_I && !step) |=> $stable(sum) && $stable(prev_bit);
    endproperty
    a_stall_hold: assert property (p_stall_hold)
        else $error("Slice state moved without a step");

    // Zero sum and low previous bit: the first bit is y0 and x0
    property p_first_bit;
        @(posedge CLOCK_I) disable iff (RST_I)
        (step && sum == '0 && !prev_bit && !RESULT_VALID_O) |=>
            RESULT_SERIAL_OUT_O == ($past(MULT_BIT_I) && $past(mcand[0]));
    endproperty
    a_first_bit: assert property (p_first_bit)
        else $error("First product bit wrong");

endmodule : sbm_slice

// file: testbench.sv
// Self-checking bench for one multiplier slice, run as top and as lower slice.
// Assumes the host model in sbm_host_model.sv; stall random, cascade random in top-slice runs.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin \
    num_errors++; $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    import sbm_pkg::*;
    logic clk = 0;
    logic rst = 1;
    logic clear_n = 0;
    logic [7:0] mcand = '0;
    logic [7:0] x_keep = '0;
    logic [7:0] y = '0;
    logic casc_rand = 0;
    logic pos_sel = 0;
    logic cascade;
    logic [15:0] want;
    logic go = 0;
    logic stall = 0;
    logic hold = 0;
    logic mult_bit, mult_valid, mult_ready, res_bit, res_valid, res_ready;
    logic done;
    logic [15:0] result_serial_out;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 32'hfa9957c5;
    int i, n;
    logic [7:0] xs [4] = '{8'h80, 8'h80, 8'hff, 8'h00};
    logic [7:0] ys [4] = '{8'h80, 8'h7f, 8'hff, 8'h5a};

    always #12.5 clk = ~clk;

    sbm_slice u_sbm_slice (.CLOCK_I(clk), .RST_I(rst), .CLEAR_N_I(clear_n),
        .MCAND_I(mcand), .MULT_BIT_I(mult_bit), .MULT_VALID_I(mult_valid),
        .MULT_READY_O(mult_ready), .CASCADE_I(cascade), .POS_SEL_I(pos_sel),
        .RESULT_SERIAL_OUT_O(res_bit), .RESULT_VALID_O(res_valid),
        .RESULT_READY_I(res_ready));

    sbm_host_model u_sbm_host_model (.clk_i(clk), .go_i(go), .mult_i(y),
        .stall_i(stall), .ready_i(mult_ready), .res_bit_i(res_bit),
        .res_valid_i(res_valid), .bit_o(mult_bit), .valid_o(mult_valid),
        .res_ready_o(res_ready), .result_serial_out_o(result_serial_out), .done_o(done));

    // Lower slice runs feed the multiplier stream back as cascade
    assign cascade = pos_sel ? mult_bit : casc_rand;

    function automatic logic [15:0] exp_result_serial_out(logic [7:0] a, logic [7:0] b,
                                             logic low);
        logic signed [15:0] p;
        p = $signed(a) * $signed(b);
        // Zero multiplicand: cascade bits come out eight steps later
        if (low) p = {b, 8'h00};
        return p;
    endfunction : exp_result_serial_out

    task automatic results;
        $display("comparisons %0d errors %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results

    // Top slice must ignore the cascade bit, so it is noise here
    always @(negedge clk) begin
        casc_rand <= $random(seed);
        stall <= hold ? 1'b1 : $random(seed);
    end

    initial begin
        #(25 * 4000);
        num_errors++;
        results;
    end

    initial begin
        repeat (10) @(negedge clk);
        `CHK("reset_valid", 1'b0, res_valid)
        rst = 0;
        for (i = 0; i < 14; i++) begin
            @(negedge clk);
            clear_n = 0;
            go = 0;
            hold = 0;
            // Last two runs act as a lower slice with zero multiplicand
            pos_sel = (i >= 12);
            x_keep = i >= 12 ? 8'h00 : i < 4 ? xs[i] : $random(seed);
            y = i < 4 ? ys[i] : $random(seed);
            mcand = x_keep;
            @(negedge clk);
            `CHK("clear_out", 2'b00, {res_bit, res_valid})
            clear_n = 1;
            go = 1;
            hold = (i == 1);
            @(negedge clk);
            mcand = ~x_keep;
            if (i == 5) begin
                repeat (4) @(negedge clk);
                clear_n = 0;
                go = 0;
                mcand = x_keep;
                @(negedge clk);
                `CHK("abort_out", 2'b00, {res_bit, res_valid})
                clear_n = 1;
                go = 1;
                @(negedge clk);
                mcand = ~x_keep;
            end
            n = 0;
            while (!done && n < 300) begin
                @(negedge clk);
                n++;
                if (i == 1 && n == 5) `CHK("full_ready", 1'b0, mult_ready)
                if (i == 1 && n == 6) hold = 0;
            end
            `CHK("done", 1'b1, done)
            want = exp_result_serial_out(x_keep, y, pos_sel);
            `CHK("product", want, result_serial_out)
            $display("test %0d done x=%h y=%h", i, x_keep, y);
        end
        results;
    end
endmodule : testbench
